// file: hdl/flash_host.sv
`timescale 1ns/100ps
`include "flash_host_defines.svh"
// Summary of operation
// - host leaves aborted program or erase for the user to reissue
// - host waits recovery time after reset
// - high voltage id: A9 elevated, A6 low
// - protect check: sector bits, A1=1, A0=0
// - in-system id uses command sequence
// - reset command leaves autoselect mode
module flash_host
    import flash_host_pkg::*;
#(
    parameter int READY_SETTLE_CYC = `READY_SETTLE_CYC
)(
    input  wire logic        clk_i,           // 200 MHz clock
    input  wire logic        nrst_i,          // async reset, active low
    input  wire logic        req_i,           // start operation, pulse
    input  wire host_op_t    op_i,            // operation kind
    input  wire id_sel_t     id_sel_i,        // which id code
    input  wire logic [3:0]  sector_i,        // sector for protect check
    input  wire logic        top_boot_i,      // device variant
    input  wire logic        byte_mode_i,     // 1 = byte mode
    input  wire logic        hv_method_i,     // use elevated A9 method
    input  wire logic [17:0] addr_i,          // array word address
    input  wire logic        addr_lsb_i,      // byte lsb (A-1)
    input  wire logic [15:0] dq_i,            // data pins in
    input  wire logic        ready_busy_n_i,  // device ready/busy pin
    output logic             busy_o,          // operation running
    output logic             done_o,          // result valid pulse
    output logic      [15:0] rdata_o,         // read result
    output logic             protected_o,     // sector protected flag
    output logic      [17:0] addr_o,          // address pins
    output logic             addr_lsb_o,      // A-1 in byte mode
    output logic      [15:0] dq_o,            // data pins out
    output logic             dq_oe_n_o,       // low while host drives dq
    output logic             ce_n_o,          // chip enable
    output logic             oe_n_o,          // output enable
    output logic             we_n_o,          // write enable
    output logic             rst_n_o,         // hardware reset pin
    output logic             elevated_id_voltage_o, // raise A9 to id level
    output logic             byte_n_o         // byte/word select pin
);
    typedef enum logic [3:0] {
        S_IDLE, S_RD_SETUP, S_RD_WAIT, S_WR_LOW, S_WR_HIGH,
        S_RST_LOW, S_RST_BUSY, S_RST_REC, S_DONE
    } state_t;

    state_t      state_r;
    logic [15:0] cnt_r;
    logic [1:0]  seq_r;
    logic [1:0]  nseq_r;
    host_op_t    op_r;
    logic        id_read_r;
    logic [5:0]  sa_bits;

    sector_decode u_dec (
        .top_boot_i (top_boot_i),
        .sector_i   (sector_i),
        .sa_bits_o  (sa_bits)
    );

    function automatic logic [7:0] wr_data(input logic [1:0] idx, input host_op_t op);
        logic [7:0] d;
        d = (idx == 2'h0) ? `UNLOCK1_DATA : (idx == 2'h1) ? `UNLOCK2_DATA
            : (op == OP_ID_EXIT) ? `RESET_CMD_DATA : `AUTOSEL_CMD_DATA;
        return d;
    endfunction

    function automatic logic [17:0] wr_addr(input logic [1:0] idx);
        return (idx == 2'h1) ? `UNLOCK2_ADDR : `UNLOCK1_ADDR;
    endfunction

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r               <= S_IDLE;
            cnt_r                 <= 16'h0000;
            seq_r                 <= 2'h0;
            nseq_r                <= 2'h0;
            op_r                  <= OP_READ;
            id_read_r             <= 1'b0;
            busy_o                <= 1'b0;
            done_o                <= 1'b0;
            rdata_o               <= 16'h0000;
            protected_o           <= 1'b0;
            addr_o                <= 18'h00000;
            addr_lsb_o            <= 1'b0;
            dq_o                  <= 16'h0000;
            dq_oe_n_o             <= 1'b1;
            ce_n_o                <= 1'b1;
            oe_n_o                <= 1'b1;
            we_n_o                <= 1'b1;
            rst_n_o               <= 1'b1;
            elevated_id_voltage_o <= 1'b0;
            byte_n_o              <= 1'b1;
        end else begin
            done_o <= 1'b0;
            unique case (state_r)
                S_IDLE: begin
                    ce_n_o                <= 1'b1;
                    oe_n_o                <= 1'b1;
                    elevated_id_voltage_o <= 1'b0;
                    byte_n_o              <= ~byte_mode_i;
                    if (req_i) begin
                        busy_o    <= 1'b1;
                        op_r      <= op_i;
                        seq_r     <= 2'h0;
                        id_read_r <= 1'b0;
                        unique case (op_i)
                            OP_READ: begin
                                // addresses held stable after read; device may sleep, data stays latched
                                addr_o     <= addr_i;
                                addr_lsb_o <= addr_lsb_i;
                                state_r    <= S_RD_SETUP;
                            end
                            OP_ID_CMD: begin
                                if (hv_method_i) begin
                                    // a9 stays low here: the id level is applied beside the pin
                                    addr_o <= {sa_bits, 2'h0, 1'b0, 2'h0, 1'b0, 4'h0,
                                               id_sel_i[1], id_sel_i[0]};
                                    elevated_id_voltage_o <= 1'b1;
                                    id_read_r  <= 1'b1;
                                    state_r    <= S_RD_SETUP;
                                end else begin
                                    nseq_r  <= 2'h2;
                                    state_r <= S_WR_LOW;
                                end
                            end
                            OP_ID_EXIT: begin
                                nseq_r  <= 2'h2;
                                state_r <= S_WR_LOW;
                            end
                            OP_HW_RESET: begin
                                rst_n_o <= 1'b0;
                                cnt_r   <= 16'(`RESET_PULSE_MIN_CYC);
                                state_r <= S_RST_LOW;
                            end
                        endcase
                    end
                end
                S_WR_LOW: begin
                    addr_o    <= wr_addr(seq_r);
                    dq_o      <= {8'h00, wr_data(seq_r, op_r)};
                    dq_oe_n_o <= 1'b0;
                    ce_n_o    <= 1'b0;
                    we_n_o    <= 1'b0;
                    cnt_r     <= 16'(`CMD_PULSE_CYC);
                    state_r   <= S_WR_HIGH;
                end
                S_WR_HIGH: begin
                    if (cnt_r != 16'h0000) begin
                        cnt_r <= cnt_r - 16'h0001;
                    end else if (we_n_o == 1'b0) begin
                        we_n_o <= 1'b1;
                        cnt_r  <= 16'(`CMD_PULSE_CYC);
                    end else begin
                        ce_n_o    <= 1'b1;
                        dq_oe_n_o <= 1'b1;
                        if (seq_r != nseq_r) begin
                            seq_r   <= seq_r + 2'h1;
                            state_r <= S_WR_LOW;
                        end else if (op_r == OP_ID_CMD) begin
                            // in-system codes: 0 maker, 1/2 part, 2/4 protect with sector bits
                            addr_o <= {sa_bits, 10'h000, 2'(id_sel_i)};
                            addr_lsb_o <= 1'b0;
                            id_read_r  <= 1'b1;
                            state_r    <= S_RD_SETUP;
                        end else begin
                            state_r <= S_DONE;
                        end
                    end
                end
                S_RD_SETUP: begin
                    ce_n_o  <= 1'b0;
                    oe_n_o  <= 1'b0;
                    we_n_o  <= 1'b1;
                    cnt_r   <= 16'(`ACCESS_CYC);
                    state_r <= S_RD_WAIT;
                end
                S_RD_WAIT: begin
                    if (cnt_r != 16'h0000) begin
                        cnt_r <= cnt_r - 16'h0001;
                    end else begin
                        if (id_read_r) begin
                            rdata_o     <= byte_mode_i ? {8'h00, dq_i[7:0]} : dq_i;
                            protected_o <= (dq_i[7:0] == `PROTECTED_VAL);
                        end else begin
                            rdata_o <= dq_i;
                        end
                        oe_n_o  <= 1'b1;
                        ce_n_o  <= 1'b1;
                        state_r <= S_DONE;
                    end
                end
                S_RST_LOW: begin
                    if (cnt_r != 16'h0000) begin
                        cnt_r <= cnt_r - 16'h0001;
                    end else begin
                        rst_n_o <= 1'b1;
                        cnt_r   <= 16'(READY_SETTLE_CYC);
                        state_r <= S_RST_BUSY;
                    end
                end
                S_RST_BUSY: begin
                    // wait for ready; bounded so a stuck pin cannot hang the host
                    if (ready_busy_n_i || cnt_r == 16'h0000) begin
                        cnt_r   <= 16'(`RESET_RECOVERY_CYC);
                        state_r <= S_RST_REC;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                S_RST_REC: begin
                    if (cnt_r != 16'h0000)
                        cnt_r <= cnt_r - 16'h0001;
                    else
                        // a cut program or erase is left for the user to reissue after done
                        state_r <= S_DONE;
                end
                S_DONE: begin
                    busy_o  <= 1'b0;
                    done_o  <= 1'b1;
                    state_r <= S_IDLE;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule

// file: hdl/flash_host_defines.svh
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

`define CLK_PERIOD_NS        5
`define ADDR_ACCESS_NS       90
`define AUTO_SLEEP_EXTRA_NS  30
`define RESET_PULSE_MIN_NS   500
`define RESET_RECOVERY_NS    50
`define READY_SETTLE_NS      20000
`define CMD_PULSE_NS         40
`define RESET_PULSE_MIN_CYC  ((`RESET_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_RECOVERY_CYC   ((`RESET_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READY_SETTLE_CYC     ((`READY_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCESS_CYC           ((`ADDR_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLEEP_CYC            ((`ADDR_ACCESS_NS + `AUTO_SLEEP_EXTRA_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CMD_PULSE_CYC        ((`CMD_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ID_ADDR_MAKER        2'h0
`define ID_ADDR_PART         2'h1
`define ID_ADDR_PROTECT      2'h2
`define UNLOCK1_ADDR         18'h00555
`define UNLOCK2_ADDR         18'h002AA
`define UNLOCK1_DATA         8'hAA
`define UNLOCK2_DATA         8'h55
`define AUTOSEL_CMD_DATA     8'h90
`define RESET_CMD_DATA       8'hF0
`define PROTECTED_VAL        8'h01
`define TOP_SECTORS_LAST     4'hA

`endif

// file: hdl/flash_host_pkg.sv
package flash_host_pkg;
    typedef enum logic [1:0] {
        OP_READ,
        OP_ID_CMD,
        OP_ID_EXIT,
        OP_HW_RESET
    } host_op_t;
    typedef enum logic [1:0] {
        ID_MAKER,
        ID_PART,
        ID_PROTECT
    } id_sel_t;
endpackage

// file: hdl/sector_decode.sv
`timescale 1ns/100ps
`include "flash_host_defines.svh"
module sector_decode
    import flash_host_pkg::*;
(
    input  wire logic       top_boot_i,  // 1 = top boot variant
    input  wire logic [3:0] sector_i,    // sector number 0..10
    output logic      [5:0] sa_bits_o    // address bits 17..12
);
    always_comb begin
        sa_bits_o = 6'h00;
        if (top_boot_i) begin
            if (sector_i < 4'h7)
                sa_bits_o = {sector_i[2:0], 3'h0};
            else if (sector_i == 4'h7)
                sa_bits_o = 6'h38;
            else if (sector_i == 4'h8)
                sa_bits_o = 6'h3C;
            else if (sector_i == 4'h9)
                sa_bits_o = 6'h3D;
            else
                sa_bits_o = 6'h3E;
        end else begin
            if (sector_i == 4'h0)
                sa_bits_o = 6'h00;
            else if (sector_i == 4'h1)
                sa_bits_o = 6'h02;
            else if (sector_i == 4'h2)
                sa_bits_o = 6'h03;
            else if (sector_i == 4'h3)
                sa_bits_o = 6'h04;
            else
                sa_bits_o = {3'(sector_i - 4'h3), 3'h0};
        end
    end
endmodule

// file: sim/flash_host_assertions.sv
`timescale 1ns/100ps
module flash_host_assertions (
    input wire logic        clk_i,                 // clock
    input wire logic        nrst_i,                // reset, active low
    input wire logic        done_o,                // result pulse
    input wire logic        busy_o,                // running
    input wire logic        ready_busy_n_i,        // device ready pin
    input wire logic [17:0] addr_o,                // address pins
    input wire logic        dq_oe_n_o,             // host drives dq when low
    input wire logic        ce_n_o,                // chip enable
    input wire logic        oe_n_o,                // output enable
    input wire logic        we_n_o,                // write enable
    input wire logic        rst_n_o,               // reset pin
    input wire logic        elevated_id_voltage_o  // id level on A9
);
    logic [7:0] low_cnt_r;  // saturates: only the minimum width matters
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i || rst_n_o) begin
            low_cnt_r <= 8'h00;
        end else if (low_cnt_r != 8'hFF) begin
            low_cnt_r <= low_cnt_r + 8'h01;
        end
    end
    a_no_bus_fight: assert property (!oe_n_o |-> we_n_o && dq_oe_n_o)
        else $error("read strobe overlaps a write or host data drive");
    a_write_cycle: assert property (!we_n_o |-> !ce_n_o && oe_n_o)
        else $error("write strobe without chip enable or with output enable");
    a_reset_width: assert property ($rose(rst_n_o) |-> low_cnt_r >= 8'h64)
        else $error("reset pin pulse shorter than the minimum");
    a_reset_recovery: assert property ($rose(rst_n_o) |-> oe_n_o [*8] ##1 oe_n_o ##1 oe_n_o)
        else $error("read started inside the reset recovery time");
    a_ready_wait: assert property (!ready_busy_n_i |=> !done_o [*8])
        else $error("operation finished while the device was busy");
    a_hv_strobes: assert property (elevated_id_voltage_o && !oe_n_o |-> !addr_o[6] && !ce_n_o)
        else $error("id level read without A6 low or chip enable");
    a_hv_pin_low: assert property (elevated_id_voltage_o |-> !addr_o[9] && we_n_o)
        else $error("A9 driven or write strobe while id level applied");
    a_done_pulse: assert property (done_o |-> !busy_o ##1 !done_o)
        else $error("done not a single idle pulse");
    a_reset_quiet: assert property (!rst_n_o |-> we_n_o && oe_n_o)
        else $error("access strobed while reset pin low");
endmodule
bind flash_host flash_host_assertions i_chk (.clk_i(clk_i), .nrst_i(nrst_i), .done_o(done_o),
    .busy_o(busy_o), .ready_busy_n_i(ready_busy_n_i), .addr_o(addr_o), .dq_oe_n_o(dq_oe_n_o),
    .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o), .rst_n_o(rst_n_o),
    .elevated_id_voltage_o(elevated_id_voltage_o));

// file: sim/flash_dev_model.sv
`timescale 1ns/100ps
`include "flash_host_defines.svh"
module flash_dev_model #(
    parameter logic [7:0]  MAKER = 8'h3C,  // arbitrary value
    parameter logic [7:0]  PTOP  = 8'h5A,  // arbitrary value
    parameter logic [7:0]  PBOT  = 8'h6B,  // arbitrary value
    parameter logic [7:0]  PHI   = 8'h47,  // arbitrary value
    parameter logic [10:0] PMASK = 11'h2A5,
    parameter int          BUSY  = 150,
    parameter int          SLEEP = `SLEEP_CYC
)(
    input  wire logic        clk_i,      // bench clock
    input  wire logic        top_i,      // top boot variant
    input  wire logic        emb_i,      // embedded operation running
    input  wire logic [17:0] addr_i,     // address pins
    input  wire logic        lsb_i,      // byte lsb
    input  wire logic [15:0] dq_host_i,  // host data
    input  wire logic        dq_oe_n_i,  // host drives when low
    input  wire logic        ce_n_i,     // chip enable
    input  wire logic        oe_n_i,     // output enable
    input  wire logic        we_n_i,     // write enable
    input  wire logic        rst_n_i,    // reset pin
    input  wire logic        hv_i,       // id level on A9
    input  wire logic        byte_n_i,   // word mode when high
    output logic      [15:0] dq_o,       // data wire level
    output logic             rb_n_o      // ready, low busy
);
    logic        id_mode = 1'b0, we_q = 1'b1, rst_q = 1'b1;
    logic [1:0]  seq = 2'h0;
    logic [7:0]  wd;
    logic [15:0] word, rd, last = 16'h0000;
    logic [3:0]  sec;
    int          cnt = 0;
    int          still = 0;
    logic [22:0] look, look_q = '0;
    logic [15:0] held;
    function automatic logic [3:0] sector_of(input logic t, input logic [5:0] a);
        if (t) begin
            return (a[5:3] != 3'h7) ? {1'b0, a[5:3]} : !a[2] ? 4'h7 : a[1] ? 4'hA : {3'h4, a[0]};
        end
        return (a[5:3] != 3'h0) ? {1'b0, a[5:3]} + 4'h3 : a[2] ? 4'h3 : a[1] ? {3'h0, a[0]} + 4'h1
            : 4'h0;
    endfunction
    assign sec = sector_of(top_i, addr_i[17:12]);
    assign word = {addr_i[15:8] ^ 8'h3C, addr_i[7:0]};
    assign look = {addr_i, lsb_i, byte_n_i, hv_i, id_mode, top_i};
    always_comb begin
        if (id_mode || (hv_i && !addr_i[6])) begin
            case (addr_i[1:0])
                2'h0: rd = {8'h00, MAKER};
                2'h1: rd = {PHI, top_i ? PTOP : PBOT};
                default: rd = {15'h0000, PMASK[sec]};
            endcase
        end else begin
            rd = byte_n_i ? word : {8'h00, lsb_i ? word[15:8] : word[7:0]};
        end
    end
    // released lines show the inverse of the last value so stale data cannot pass;
    // once asleep the output comes from the latch taken before sleep
    assign dq_o = !dq_oe_n_i ? dq_host_i
        : (!ce_n_i && !oe_n_i && rst_n_i) ? ((still >= SLEEP) ? held : rd) : ~last;
    assign rb_n_o = (cnt == 0);
    always @(posedge clk_i) begin
        we_q <= we_n_i;
        rst_q <= rst_n_i;
        look_q <= look;
        still <= (look == look_q) ? still + 1 : 0;
        if (still < SLEEP) held <= rd;
        if (!ce_n_i && !oe_n_i && rst_n_i) last <= rd;
        if (!we_n_i && !ce_n_i) wd <= dq_host_i[7:0];
        if (cnt > 0) cnt <= cnt - 1;
        if (!rst_n_i) begin
            id_mode <= 1'b0;
            seq <= 2'h0;
            if (emb_i && rst_q) cnt <= BUSY;
        end else if (we_n_i && !we_q) begin
            seq <= (seq == 2'h0 && wd == 8'hAA) ? 2'h1 : (seq == 2'h1 && wd == 8'h55) ? 2'h2 : 2'h0;
            if (seq == 2'h2 && wd == 8'h90) id_mode <= 1'b1;
            if (wd == 8'hF0) id_mode <= 1'b0;
        end
    end
endmodule

// file: sim/test_flash_host.sv
`timescale 1ns/100ps
module test_flash_host;
    import flash_host_pkg::*;
    localparam logic [10:0] PMASK = 11'h2A5;
    logic        clk_i = 0, nrst_i = 0, req_i = 0, top_boot_i = 0, byte_mode_i = 0;
    logic        hv_method_i = 0, addr_lsb_i = 0, emb = 0, rb_q = 1;
    host_op_t    op_i = OP_READ;
    id_sel_t     id_sel_i = ID_MAKER;
    logic [3:0]  sector_i = 4'h0;
    logic [17:0] addr_i = 18'h00000, addr_o;
    logic [15:0] dq_i, rdata_o, dq_o, exp;
    logic        ready_busy_n_i, busy_o, done_o, protected_o, addr_lsb_o, dq_oe_n_o;
    logic        ce_n_o, oe_n_o, we_n_o, rst_n_o, elevated_id_voltage_o, byte_n_o;
    int          bad_count = 0, n_compared = 0, cyc = 0, rise_cyc = 0, done_cyc = 0;
    flash_host #(.READY_SETTLE_CYC(100)) i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req_i),
        .op_i(op_i), .id_sel_i(id_sel_i), .sector_i(sector_i), .top_boot_i(top_boot_i),
        .byte_mode_i(byte_mode_i), .hv_method_i(hv_method_i), .addr_i(addr_i),
        .addr_lsb_i(addr_lsb_i), .dq_i(dq_i), .ready_busy_n_i(ready_busy_n_i), .busy_o(busy_o),
        .done_o(done_o), .rdata_o(rdata_o), .protected_o(protected_o), .addr_o(addr_o),
        .addr_lsb_o(addr_lsb_o), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .ce_n_o(ce_n_o),
        .oe_n_o(oe_n_o), .we_n_o(we_n_o), .rst_n_o(rst_n_o), .byte_n_o(byte_n_o),
        .elevated_id_voltage_o(elevated_id_voltage_o));
    flash_dev_model #(.PMASK(PMASK)) i_dev (.clk_i(clk_i), .top_i(top_boot_i), .emb_i(emb),
        .addr_i(addr_o), .lsb_i(addr_lsb_o), .dq_host_i(dq_o), .dq_oe_n_i(dq_oe_n_o),
        .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o), .rst_n_i(rst_n_o),
        .hv_i(elevated_id_voltage_o), .byte_n_i(byte_n_o), .dq_o(dq_i), .rb_n_o(ready_busy_n_i));
    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (ready_busy_n_i && !rb_q) rise_cyc = cyc;
        rb_q = ready_busy_n_i;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        n_compared++;
        if (seen !== want) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic run_op(input host_op_t op, input id_sel_t sel);
        int n;
        n = 0;
        @(posedge clk_i);
        op_i <= op;
        id_sel_i <= sel;
        req_i <= 1'b1;
        @(posedge clk_i);
        req_i <= 1'b0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (done_o !== 1'b1 && n < 3000);
        done_cyc = cyc;
        check("done", {15'h0000, done_o}, 16'h0001);
    endtask
    task automatic t_read(input logic [17:0] a, input logic bm, input logic lsb);
        @(posedge clk_i);
        addr_i <= a;
        byte_mode_i <= bm;
        addr_lsb_i <= lsb;
        run_op(OP_READ, ID_MAKER);
        exp = {a[15:8] ^ 8'h3C, a[7:0]};
        if (bm) exp = {8'h00, lsb ? exp[15:8] : exp[7:0]};
        check("array read", bm ? {8'h00, rdata_o[7:0]} : rdata_o, exp);
    endtask
    task automatic t_ident();
        for (int v = 0; v < 8; v++) begin
            @(posedge clk_i);
            top_boot_i <= v[0];
            byte_mode_i <= v[1];
            hv_method_i <= v[2];
            run_op(OP_ID_CMD, ID_MAKER);
            check("maker code", {8'h00, rdata_o[7:0]}, 16'h003C);
            run_op(OP_ID_CMD, ID_PART);
            exp = {v[1] ? 8'h00 : 8'h47, v[0] ? 8'h5A : 8'h6B};
            check("part code", rdata_o, exp);
            run_op(OP_ID_EXIT, ID_MAKER);
            t_read(18'h3FFFF, v[1], 1'b1);
        end
    endtask
    task automatic t_protect();
        for (int v = 0; v < 44; v++) begin
            @(posedge clk_i);
            top_boot_i <= v[0];
            hv_method_i <= v[1];
            sector_i <= 4'(v / 4);
            run_op(OP_ID_CMD, ID_PROTECT);
            check("protect flag", {15'h0000, protected_o}, {15'h0000, PMASK[v / 4]});
        end
        @(posedge clk_i);
        hv_method_i <= 1'b0;
        run_op(OP_ID_EXIT, ID_MAKER);
    endtask
    task automatic t_hw_reset(input logic e);
        run_op(OP_ID_CMD, ID_MAKER);
        emb <= e;
        rise_cyc = 0;
        run_op(OP_HW_RESET, ID_MAKER);
        emb <= 1'b0;
        if (e) check("recovery gap", 16'(done_cyc - rise_cyc >= 10 && rise_cyc > 0), 16'h0001);
        t_read(18'h12345, 1'b0, 1'b0);
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_read(18'h00000, 1'b0, 1'b0);
        t_read(18'h3FFFF, 1'b0, 1'b0);
        t_read(18'h2A5A6, 1'b1, 1'b1);
        t_read(18'h2A5A6, 1'b1, 1'b0);
        t_ident();
        t_protect();
        t_hw_reset(1'b1);
        t_hw_reset(1'b0);
        complete_run();
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        bad_count++;
        complete_run();
    end
endmodule
